// ==== hdl/serial_port_config_status.sv ====
/*
  Configuration, interrupt mask and error status bank of the host serial
  port (UART or SPI), reached over AHB-Lite, zero wait states.
  Assumes the framing engines run on hclk and report one-cycle strobes.
*/
// How it works
// - CRC polynomial is an eight-bit writable field, reset to 0x07.
// - Noise enable bit, reset clear; noisy bit sets noise flag when enabled.
// - Break-on-error enable bit, reset clear, driven to the UART engine.
// - CRC append enable, set at reset; both sides send a fifth CRC byte.
// - Bit order select: zero big-endian, one little-endian; host matches it.
// - Timeout field in milliseconds; expiry sets the timeout flag.
// - Sixteen-bit baud divisor, reset value gives 9600 baud.
// - Thirteen mask bits route flags to both interrupt outputs; reset clear.
// - An all-zero received frame sets the UART break flag.
// - A non-zero character without stop bit sets the framing flag.
// - Unprocessed received data overrun sets the UART receive overrun flag.
// - Host sending before reception ends sets UART transmit overrun flag.
// - SPI receive-full and transmit-empty flags are provided for diagnostics.
// - Host read outside implemented rows sets the read address flag.
// - Host write outside implemented rows sets the write address flag.
// - Too-fast SPI read-back sets the transmit underrun flag.
// - Too-close SPI writes set the receive overrun flag.
`timescale 1ns/1ps
`include "serial_port_regs.svh"

module serial_port_config_status #(
  parameter int unsigned MS_CYCLES = `SP_MS_NS / `SP_CLK_NS
) (
  // Clock and reset
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  // AHB-Lite slave
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  // Framing engine reports
  input  wire serial_port_pkg::uart_char_s   uart_char,
  input  wire serial_port_pkg::crc_check_s   crc_check,
  input  wire serial_port_pkg::host_access_s host_access,
  input  wire serial_port_pkg::link_events_s link_events,
  input  wire logic                         rx_busy,
  // Configuration and interrupts
  output serial_port_pkg::serial_cfg_s       cfg,
  output logic                              irq_out_a,
  output logic                              irq_out_b
);

  serial_port_pkg::reg_sel_e dsel;
  serial_port_pkg::reg_sel_e next_dsel;
  logic                      dwrite;
  logic                      next_dwrite;
  logic [31:0]               next_hrdata;
  logic [31:0]               ctrl;
  logic [31:0]               next_ctrl;
  logic [31:0]               baud;
  logic [31:0]               next_baud;
  logic [31:0]               irq_reg;
  logic [31:0]               next_irq_reg;
  logic [31:0]               ev;
  logic [31:0]               clr;
  logic [17:0]               tick_cnt;
  logic [17:0]               next_tick_cnt;
  logic [7:0]                ms_cnt;
  logic [7:0]                next_ms_cnt;
  logic                      tmo_done;
  logic                      next_tmo_done;
  logic                      tmo_hit;
  logic                      acc;
  serial_port_pkg::reg_sel_e asel;
  logic [14:1]               irq_hit;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase decode
  always_comb begin
    acc  = hsel & htrans[1] & hready;
    asel = serial_port_pkg::SEL_NONE;
    unique case (haddr[11:0])
      `SP_CTRL_OFS: asel = serial_port_pkg::SEL_CTRL;
      `SP_BAUD_OFS: asel = serial_port_pkg::SEL_BAUD;
      `SP_IRQ_OFS:  asel = serial_port_pkg::SEL_IRQ;
      default:      asel = serial_port_pkg::SEL_NONE;
    endcase
    if (haddr[31:12] != 20'h0_0000) begin
      asel = serial_port_pkg::SEL_NONE;
    end
  end

  // Bus data phase tracking; read data taken from the next register values
  always_comb begin
    next_dsel   = serial_port_pkg::SEL_NONE;
    next_dwrite = 1'b0;
    next_hrdata = hrdata;
    if (acc) begin
      next_dsel   = asel;
      next_dwrite = hwrite;
      if (!hwrite) begin
        unique case (asel)
          serial_port_pkg::SEL_CTRL: next_hrdata = next_ctrl;
          serial_port_pkg::SEL_BAUD: next_hrdata = next_baud;
          serial_port_pkg::SEL_IRQ:  next_hrdata = next_irq_reg;
          serial_port_pkg::SEL_NONE: next_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dsel   <= serial_port_pkg::SEL_NONE;
      dwrite <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      dsel   <= next_dsel;
      dwrite <= next_dwrite;
      hrdata <= next_hrdata;
    end
  end

  // Receive timeout: millisecond ticks while a reception is under way
  always_comb begin
    next_tick_cnt = tick_cnt;
    next_ms_cnt   = ms_cnt;
    next_tmo_done = tmo_done;
    tmo_hit       = 1'b0;
    if (!rx_busy || uart_char.valid) begin
      next_tick_cnt = 18'h0_0000;
      next_ms_cnt   = 8'h00;
      next_tmo_done = 1'b0;
    end else if (tick_cnt == 18'(MS_CYCLES - 1)) begin
      next_tick_cnt = 18'h0_0000;
      if (ms_cnt != 8'hFF) begin
        next_ms_cnt = ms_cnt + 8'h01;
      end
    end else begin
      next_tick_cnt = tick_cnt + 18'h0_0001;
    end
    if (rx_busy && !tmo_done && cfg.timeout_ms != 8'h00 && ms_cnt == cfg.timeout_ms) begin
      tmo_hit       = 1'b1;
      next_tmo_done = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= 18'h0_0000;
      ms_cnt   <= 8'h00;
      tmo_done <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      ms_cnt   <= next_ms_cnt;
      tmo_done <= next_tmo_done;
    end
  end

  // Status events
  always_comb begin
    ev = 32'h0000_0000;
    ev[`SP_ST_BREAK] = uart_char.valid & ~uart_char.stop_ok & (uart_char.data == 8'h00);
    ev[`SP_ST_UFRAME] = uart_char.valid & ~uart_char.stop_ok & (uart_char.data != 8'h00);
    ev[`SP_ST_UNOISE] = uart_char.valid & uart_char.noisy & cfg.noise_enable;
    ev[`SP_ST_UCRC] = crc_check.valid & cfg.crc_append_enable & ~crc_check.spi_port
                      & (crc_check.rx_crc != crc_check.calc_crc);
    ev[`SP_ST_SCRC] = crc_check.valid & cfg.crc_append_enable & crc_check.spi_port
                      & (crc_check.rx_crc != crc_check.calc_crc);
    ev[`SP_ST_UTMO] = tmo_hit;
    ev[`SP_ST_URXOVR] = link_events.uart_rx_overrun;
    ev[`SP_ST_UTXOVR] = link_events.uart_tx_overrun;
    ev[`SP_ST_SRXFULL]  = link_events.spi_rx_full;
    ev[`SP_ST_STXEMPTY] = link_events.spi_tx_empty;
    ev[`SP_ST_RDADDR] = host_access.valid & ~host_access.write & (host_access.row > `SP_LAST_ROW);
    ev[`SP_ST_WRADDR] = host_access.valid & host_access.write & (host_access.row > `SP_LAST_ROW);
    ev[`SP_ST_STXUNDR] = link_events.spi_tx_underrun;
    ev[`SP_ST_SRXOVR]  = link_events.spi_rx_overrun;
  end

  // Register writes; status bits clear on writing one, a new event wins
  always_comb begin
    next_ctrl    = ctrl;
    next_baud    = baud;
    next_irq_reg = irq_reg | ev;
    clr          = 32'h0000_0000;
    if (dwrite) begin
      unique case (dsel)
        serial_port_pkg::SEL_CTRL: next_ctrl = hwdata & `SP_CTRL_WMASK;
        serial_port_pkg::SEL_BAUD: next_baud = hwdata & `SP_BAUD_WMASK;
        serial_port_pkg::SEL_IRQ: begin
          clr          = {hwdata[31:`SP_ST_LSB], 16'h0000};
          next_irq_reg = ((irq_reg & ~clr & ~`SP_MASK_WMASK) | (hwdata & `SP_MASK_WMASK)) | ev;
        end
        serial_port_pkg::SEL_NONE: next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl    <= `SP_CTRL_RST;
      baud    <= `SP_BAUD_RST;
      irq_reg <= `SP_IRQ_RST;
    end else begin
      ctrl    <= next_ctrl;
      baud    <= next_baud;
      irq_reg <= next_irq_reg;
    end
  end

  // Fields to the framing engines
  always_comb begin
    cfg.crc_generator_poly = ctrl[`SP_POLY_LSB +: 8];
    cfg.noise_enable       = ctrl[`SP_NOISE_EN_BIT];
    cfg.break_on_error     = ctrl[`SP_BREAK_EN_BIT];
    cfg.crc_append_enable  = ctrl[`SP_CRC_EN_BIT];
    cfg.bit_order_select   = ctrl[`SP_ORDER_BIT];
    cfg.timeout_ms         = ctrl[`SP_TMO_LSB +: 8];
    cfg.baud_divisor       = baud[`SP_BAUD_LSB +: 16];
    cfg.frame_delay        = baud[`SP_FDELAY_LSB +: 8];
  end

  // mask bit n gates status bit n+16
  for (genvar i = 1; i <= 14; i++) begin : g_route
    assign irq_hit[i] = irq_reg[i + 16] & irq_reg[i];
  end

  // both outputs carry every flag whose mask bit is set; the break flag has no mask bit and never reaches them
  assign irq_out_a = |irq_hit;
  assign irq_out_b = |irq_hit;

  default clocking dflt_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Interrupt routing
  a_irq_both_equal: assert property (irq_out_a == irq_out_b)
    else $error("interrupt outputs differ");
  a_irq_needs_mask: assert property (irq_out_a |-> |(irq_reg[30:17] & irq_reg[14:1]))
    else $error("interrupt without unmasked flag");
  a_break_no_irq: assert property (irq_reg[31:17] == 15'h0000 |-> !irq_out_a)
    else $error("break flag raised an interrupt");
  a_mask_write: assert property (dwrite && dsel == serial_port_pkg::SEL_IRQ
                                 |=> (irq_reg & `SP_MASK_WMASK)
                                 == ($past(hwdata) & `SP_MASK_WMASK))
    else $error("mask write not applied");
  a_status_sticky: assert property (!(dwrite && dsel == serial_port_pkg::SEL_IRQ)
                                    |=> (irq_reg[31:16] & $past(irq_reg[31:16]))
                                    == $past(irq_reg[31:16]))
    else $error("status flag dropped without a clear");

  // UART flags
  a_noise_when_on: assert property (uart_char.valid && uart_char.noisy
                                    && cfg.noise_enable |=> irq_reg[`SP_ST_UNOISE])
    else $error("noise flag not set");
  a_noise_when_off: assert property (uart_char.valid && uart_char.noisy
                                     && !cfg.noise_enable && !irq_reg[`SP_ST_UNOISE]
                                     |=> !irq_reg[`SP_ST_UNOISE])
    else $error("noise flag set while disabled");
  a_break_frame: assert property (uart_char.valid && !uart_char.stop_ok
                                  && uart_char.data == 8'h00 |=> irq_reg[`SP_ST_BREAK])
    else $error("break flag not set");
  a_break_not_frame: assert property (uart_char.valid && uart_char.data == 8'h00
                                      && !irq_reg[`SP_ST_UFRAME] |=> !irq_reg[`SP_ST_UFRAME])
    else $error("break frame taken as framing error");
  a_framing_flag: assert property (uart_char.valid && !uart_char.stop_ok
                                   && uart_char.data != 8'h00 |=> irq_reg[`SP_ST_UFRAME])
    else $error("framing flag not set");
  a_uart_rx_ovr: assert property (link_events.uart_rx_overrun |=> irq_reg[`SP_ST_URXOVR])
    else $error("UART receive overrun flag not set");
  a_uart_tx_ovr: assert property (link_events.uart_tx_overrun |=> irq_reg[`SP_ST_UTXOVR])
    else $error("UART transmit overrun flag not set");
  a_timeout_flag: assert property (tmo_hit |-> ms_cnt == cfg.timeout_ms
                                   ##1 irq_reg[`SP_ST_UTMO])
    else $error("timeout flag not set at expiry");
  a_timeout_off: assert property (cfg.timeout_ms == 8'h00 |-> !tmo_hit)
    else $error("timeout fired while disabled");
  a_timeout_once: assert property (tmo_hit |=> !tmo_hit)
    else $error("timeout fired twice");

  // CRC and address flags
  a_crc_port_flag: assert property (crc_check.valid && cfg.crc_append_enable
                                    && crc_check.rx_crc != crc_check.calc_crc
                                    |=> ($past(crc_check.spi_port) ? irq_reg[`SP_ST_SCRC]
                                    : irq_reg[`SP_ST_UCRC]))
    else $error("CRC flag not set on its port");
  a_crc_off: assert property (crc_check.valid && !cfg.crc_append_enable
                              && !irq_reg[`SP_ST_UCRC] && !irq_reg[`SP_ST_SCRC]
                              |=> !irq_reg[`SP_ST_UCRC] && !irq_reg[`SP_ST_SCRC])
    else $error("CRC flag set while CRC is off");
  a_rd_addr_flag: assert property (host_access.valid && !host_access.write
                                   && host_access.row > `SP_LAST_ROW
                                   |=> irq_reg[`SP_ST_RDADDR])
    else $error("read address flag not set");
  a_wr_addr_flag: assert property (host_access.valid && host_access.write
                                   && host_access.row > `SP_LAST_ROW
                                   |=> irq_reg[`SP_ST_WRADDR])
    else $error("write address flag not set");
  a_rd_addr_quiet: assert property (host_access.valid && !irq_reg[`SP_ST_RDADDR]
                                    && host_access.row <= `SP_LAST_ROW
                                    |=> !irq_reg[`SP_ST_RDADDR])
    else $error("read address flag set in range");
  a_wr_addr_quiet: assert property (host_access.valid && !irq_reg[`SP_ST_WRADDR]
                                    && host_access.row <= `SP_LAST_ROW
                                    |=> !irq_reg[`SP_ST_WRADDR])
    else $error("write address flag set in range");

  // SPI flags
  a_spi_rx_full: assert property (link_events.spi_rx_full |=> irq_reg[`SP_ST_SRXFULL])
    else $error("SPI receive full flag not set");
  a_spi_tx_empty: assert property (link_events.spi_tx_empty |=> irq_reg[`SP_ST_STXEMPTY])
    else $error("SPI transmit empty flag not set");
  a_spi_underrun: assert property (link_events.spi_tx_underrun
                                   |=> irq_reg[`SP_ST_STXUNDR])
    else $error("SPI underrun flag not set");
  a_spi_overrun: assert property (link_events.spi_rx_overrun
                                  |=> irq_reg[`SP_ST_SRXOVR]
                                  ##1 (irq_reg[`SP_ST_SRXOVR] || ($past(dwrite)
                                  && $past(dsel) == serial_port_pkg::SEL_IRQ
                                  && $past(hwdata[`SP_ST_SRXOVR]))))
    else $error("SPI overrun flag lost");

  // Register writes, read data and bus answer
  a_poly_write: assert property (dwrite && dsel == serial_port_pkg::SEL_CTRL
                                 |=> cfg.crc_generator_poly == $past(hwdata[7:0])
                                 && cfg.bit_order_select == $past(hwdata[15]))
    else $error("control write not applied");
  a_noise_en_write: assert property (dwrite && dsel == serial_port_pkg::SEL_CTRL
                                     |=> cfg.noise_enable == $past(hwdata[`SP_NOISE_EN_BIT]))
    else $error("noise enable write not applied");
  a_break_en_write: assert property (dwrite && dsel == serial_port_pkg::SEL_CTRL
                                     |=> cfg.break_on_error == $past(hwdata[`SP_BREAK_EN_BIT]))
    else $error("break enable write not applied");
  a_crc_en_write: assert property (dwrite && dsel == serial_port_pkg::SEL_CTRL
                                   |=> cfg.crc_append_enable == $past(hwdata[`SP_CRC_EN_BIT]))
    else $error("CRC enable write not applied");
  a_timeout_write: assert property (dwrite && dsel == serial_port_pkg::SEL_CTRL
                                    |=> cfg.timeout_ms == $past(hwdata[`SP_TMO_LSB +: 8]))
    else $error("timeout write not applied");
  a_baud_write: assert property (dwrite && dsel == serial_port_pkg::SEL_BAUD
                                 |=> cfg.baud_divisor == $past(hwdata[15:0]))
    else $error("divisor write not applied");
  a_read_baud: assert property (acc && !hwrite && asel == serial_port_pkg::SEL_BAUD
                                |=> hrdata == baud)
    else $error("divisor read data wrong");
  a_read_status: assert property (acc && !hwrite && asel == serial_port_pkg::SEL_IRQ
                                  |=> hrdata == irq_reg)
    else $error("status read data wrong");
  a_reserved_zero: assert property ((ctrl & ~`SP_CTRL_WMASK) == 32'h0000_0000
                                    && (baud & ~`SP_BAUD_WMASK) == 32'h0000_0000)
    else $error("reserved bits set");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");

  c_irq_raised: cover property ($rose(irq_out_a));
  c_timeout_hit: cover property (tmo_hit);
  c_spi_crc_err: cover property (ev[`SP_ST_SCRC]);
  c_set_and_clear: cover property (dwrite && dsel == serial_port_pkg::SEL_IRQ && |(clr & ev));
  c_break_frame: cover property (ev[`SP_ST_BREAK]);

endmodule : serial_port_config_status

// ==== hdl/serial_port_regs.svh ====
/*
  Register offsets, field positions, reset values and timing counts for the
  serial port configuration and status bank.
  Assumes byte addressing on a 32-bit AHB-Lite bus, one word per register.
*/
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// Byte offsets
`define SP_CTRL_OFS      12'h000
`define SP_BAUD_OFS      12'h004
`define SP_IRQ_OFS       12'h008

// Reset values
`define SP_CTRL_RST      32'h0000_4007
`define SP_BAUD_RST      32'h0000_0683
`define SP_IRQ_RST       32'h0000_0000

// Writable bits; reserved bits read zero
`define SP_CTRL_WMASK    32'h00FF_C3FF
`define SP_BAUD_WMASK    32'h00FF_FFFF
`define SP_MASK_WMASK    32'h0000_7F7E

// Control fields
`define SP_POLY_LSB      0
`define SP_NOISE_EN_BIT  8
`define SP_BREAK_EN_BIT  9
`define SP_CRC_EN_BIT    14
`define SP_ORDER_BIT     15
`define SP_TMO_LSB       16
`define SP_BAUD_LSB      0
`define SP_FDELAY_LSB    16

// Status flag positions
`define SP_ST_LSB        16
`define SP_ST_BREAK      16
`define SP_ST_UCRC       17
`define SP_ST_UTMO       18
`define SP_ST_UFRAME     19
`define SP_ST_UNOISE     20
`define SP_ST_URXOVR     21
`define SP_ST_UTXOVR     22
`define SP_ST_SRXFULL    24
`define SP_ST_STXEMPTY   25
`define SP_ST_RDADDR     26
`define SP_ST_WRADDR     27
`define SP_ST_SCRC       28
`define SP_ST_STXUNDR    29
`define SP_ST_SRXOVR     30

// Last implemented host register row
`define SP_LAST_ROW      7'h16

// Timeout unit
`define SP_MS_NS         1000000
`define SP_CLK_NS        5

`endif

// ==== hdl/serial_port_pkg.sv ====
/*
  Types shared by the serial port configuration and status bank.
  Assumes the framing engines deliver one-cycle event strobes on hclk.
*/
package serial_port_pkg;

  typedef enum logic [1:0] {SEL_NONE, SEL_CTRL, SEL_BAUD, SEL_IRQ} reg_sel_e;

  typedef struct packed {
    logic [7:0]  crc_generator_poly;
    logic        noise_enable;
    logic        break_on_error;
    logic        crc_append_enable;
    logic        bit_order_select;
    logic [7:0]  timeout_ms;
    logic [15:0] baud_divisor;
    logic [7:0]  frame_delay;
  } serial_cfg_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       stop_ok;
    logic       noisy;
  } uart_char_s;

  typedef struct packed {
    logic       valid;
    logic       spi_port;
    logic [7:0] rx_crc;
    logic [7:0] calc_crc;
  } crc_check_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [6:0] row;
  } host_access_s;

  typedef struct packed {
    logic uart_rx_overrun;
    logic uart_tx_overrun;
    logic spi_rx_full;
    logic spi_tx_empty;
    logic spi_tx_underrun;
    logic spi_rx_overrun;
  } link_events_s;

endpackage : serial_port_pkg

// ==== tb/host_link_model.sv ====
/*
  Stand-in for the framing engines and the host behind them.
  Assumes callers enter just after a rising hclk edge.
*/
`timescale 1ns/1ps

module host_link_model (
  // Clock
  input  wire logic                    hclk,
  // Reports toward the register bank
  output serial_port_pkg::uart_char_s   uart_char,
  output serial_port_pkg::crc_check_s   crc_check,
  output serial_port_pkg::host_access_s host_access,
  output serial_port_pkg::link_events_s link_events,
  output logic                          rx_busy
);
  initial begin
    uart_char = '0;
    crc_check = '0;
    host_access = '0;
    link_events = '0;
    rx_busy = 1'b0;
  end
  // received characters; released fields show the inverse
  task automatic send_char(input logic [7:0] d, input logic stp, input logic nz);
    uart_char <= '{valid: 1'b1, data: d, stop_ok: stp, noisy: nz};
    @(posedge hclk);
    uart_char <= '{valid: 1'b0, data: ~d, stop_ok: ~stp, noisy: ~nz};
  endtask : send_char
  task automatic send_crc(input logic spi, input logic [7:0] rx, input logic [7:0] calc);
    crc_check <= '{valid: 1'b1, spi_port: spi, rx_crc: rx, calc_crc: calc};
    @(posedge hclk);
    crc_check <= '{valid: 1'b0, spi_port: ~spi, rx_crc: ~rx, calc_crc: ~calc};
  endtask : send_crc
  task automatic send_access(input logic wr, input logic [6:0] row);
    host_access <= '{valid: 1'b1, write: wr, row: row};
    @(posedge hclk);
    host_access <= '{valid: 1'b0, write: ~wr, row: ~row};
  endtask : send_access
  task automatic send_event(input logic [5:0] ev);
    link_events <= ev;
    @(posedge hclk);
    link_events <= '0;
  endtask : send_event
  task automatic set_busy(input logic b);
    rx_busy <= b;
  endtask : set_busy
endmodule : host_link_model

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for the serial port configuration and status bank.
  Assumes the host link model drives the framing engine reports.
*/
`timescale 1ns/1ps
`include "serial_port_regs.svh"

module tb_top;
  localparam int unsigned MS_CYC = 10;
  localparam logic [31:0] MSK = 32'h0000_7F7E;
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        irq_out_a;
  logic        irq_out_b;
  logic        rx_busy;
  logic [31:0] rd;
  int          err_count;
  int          comparisons;
  int          ev_bit [6] = '{21, 22, 24, 25, 29, 30};
  serial_port_pkg::uart_char_s   uart_char;
  serial_port_pkg::crc_check_s   crc_check;
  serial_port_pkg::host_access_s host_access;
  serial_port_pkg::link_events_s link_events;
  serial_port_pkg::serial_cfg_s  cfg;

  serial_port_config_status #(.MS_CYCLES(MS_CYC)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .uart_char(uart_char),
    .crc_check(crc_check), .host_access(host_access), .link_events(link_events),
    .rx_busy(rx_busy), .cfg(cfg), .irq_out_a(irq_out_a), .irq_out_b(irq_out_b)
  );
  host_link_model pm (
    .hclk(hclk), .uart_char(uart_char), .crc_check(crc_check),
    .host_access(host_access), .link_events(link_events), .rx_busy(rx_busy)
  );

  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // One single transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      err_count++;
      $display("unexpected at %0t: bus transfer timed out", $time);
      finish_test();
    end
  endtask : xfer

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
  endtask : rchk

  // Flag set, irq level, then write-one clear
  task automatic flag_seen(input int b, input logic irq);
    rchk(`SP_IRQ_OFS, MSK | (32'h1 << b), "flag set");
    chk({irq_out_a, irq_out_b}, {2{irq}}, "irq level");
    xfer(1'b1, `SP_IRQ_OFS, MSK | (32'h1 << b));
    rchk(`SP_IRQ_OFS, MSK, "flag cleared");
    chk({irq_out_a, irq_out_b}, 2'b00, "irq after clear");
  endtask : flag_seen

  task automatic t_reset();
    rchk(`SP_CTRL_OFS, 32'h0000_4007, "ctrl reset");
    rchk(`SP_BAUD_OFS, 32'h0000_0683, "baud reset");
    rchk(`SP_IRQ_OFS, 32'h0000_0000, "irq reset");
    chk(cfg, 44'h072_0006_8300, "cfg reset");
    chk({irq_out_a, irq_out_b}, 2'b00, "irq reset level");
  endtask : t_reset

  task automatic t_rw();
    xfer(1'b1, `SP_CTRL_OFS, 32'hFFFF_FFFF);
    rchk(`SP_CTRL_OFS, 32'h00FF_C3FF, "ctrl fields");
    xfer(1'b1, `SP_BAUD_OFS, 32'hFFFF_FFFF);
    rchk(`SP_BAUD_OFS, 32'h00FF_FFFF, "baud fields");
    chk(cfg, 44'hFFF_FFFF_FFFF, "cfg all set");
    xfer(1'b1, `SP_IRQ_OFS, 32'hFFFF_FFFF);
    rchk(`SP_IRQ_OFS, MSK, "mask bits");
    xfer(1'b1, 32'h0000_000C, 32'hFFFF_FFFF);
    rchk(32'h0000_000C, 32'h0000_0000, "unmapped");
    chk(hresp, 1'b0, "okay response");
    xfer(1'b1, `SP_CTRL_OFS, 32'h0000_4107);
  endtask : t_rw

  task automatic t_events();
    for (int i = 0; i < 6; i++) begin
      pm.send_event(6'b10_0000 >> i);
      flag_seen(ev_bit[i], 1'b1);
    end
    pm.send_char(8'h00, 1'b0, 1'b0);
    flag_seen(16, 1'b0);
    pm.send_char(8'h5A, 1'b0, 1'b0);
    flag_seen(19, 1'b1);
    pm.send_char(8'h5A, 1'b1, 1'b1);
    flag_seen(20, 1'b1);
    pm.send_crc(1'b0, 8'h12, 8'h34);
    flag_seen(17, 1'b1);
    pm.send_crc(1'b1, 8'h12, 8'h34);
    flag_seen(28, 1'b1);
    pm.send_access(1'b0, 7'h17);
    flag_seen(26, 1'b1);
    pm.send_access(1'b1, 7'h17);
    flag_seen(27, 1'b1);
  endtask : t_events

  task automatic t_refused();
    xfer(1'b1, `SP_CTRL_OFS, 32'h0000_0007);
    pm.send_char(8'h5A, 1'b1, 1'b1);
    rchk(`SP_IRQ_OFS, MSK, "noise off");
    pm.send_crc(1'b0, 8'h12, 8'h34);
    rchk(`SP_IRQ_OFS, MSK, "crc off");
    pm.send_access(1'b1, 7'h16);
    rchk(`SP_IRQ_OFS, MSK, "last row");
    xfer(1'b1, `SP_IRQ_OFS, 32'h0000_0000);
    pm.send_event(6'b00_0001);
    rchk(`SP_IRQ_OFS, 32'h4000_0000, "masked flag");
    chk({irq_out_a, irq_out_b}, 2'b00, "masked irq");
    xfer(1'b1, `SP_IRQ_OFS, 32'h4000_0000);
  endtask : t_refused

  task automatic t_timeout();
    int n;
    xfer(1'b1, `SP_CTRL_OFS, 32'h0002_4007);
    xfer(1'b1, `SP_IRQ_OFS, 32'h0000_0004);
    pm.set_busy(1'b1);
    n = 0;
    do begin @(posedge hclk); n++; end while (irq_out_a !== 1'b1 && n < 100);
    chk(n >= 2 * MS_CYC - 1 && n <= 2 * MS_CYC + 4, 1'b1, "timeout delay");
    pm.set_busy(1'b0);
    rchk(`SP_IRQ_OFS, 32'h0004_0004, "timeout flag");
  endtask : t_timeout

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  initial begin
    hresetn = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = '0;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_rw();
    t_events();
    t_refused();
    t_timeout();
    finish_test();
  end
endmodule : tb_top
